//--- hdl/stop_monitor_params.svh
`ifndef STOP_MONITOR_PARAMS_SVH
`define STOP_MONITOR_PARAMS_SVH
`define CLOCK_MHZ 200
`define WINDOW_NEW_MS 1000
`define WINDOW_OLD_MS 10
`define WINDOW_NEW_CYCLES (`WINDOW_NEW_MS * 1000 * `CLOCK_MHZ)
`define WINDOW_OLD_CYCLES (`WINDOW_OLD_MS * 1000 * `CLOCK_MHZ)
`define REACTION_MAX_MS 100
`define REACTION_MAX_CYCLES (`REACTION_MAX_MS * 1000 * `CLOCK_MHZ)
`define SYNC_STAGES 2
`endif

//--- hdl/stop_monitor_pkg.sv
package stop_monitor_pkg;
	typedef enum logic [2:0] {
		st_safe = 3'b000,
		st_ready = 3'b001,
		st_run = 3'b010,
		st_mismatch = 3'b011,
		st_open = 3'b100,
		st_fault = 3'b101
	} monitor_state_type;
endpackage

//--- hdl/channel_sync.sv
module channel_sync #(
	parameter int STAGES = 2
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Pin and result
	input wire logic pin,
	output logic synced
);
	logic [STAGES-1:0] chain;

	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			chain <= '0;
		end else if (clk_en) begin
			chain <= {chain[STAGES-2:0], pin};
		end
	end

	assign synced = chain[STAGES-1];
endmodule // channel_sync

//--- hdl/safe_stop_monitor.sv
// Behaviour
// - Ready or run only with both channels powered
// - Either channel drop removes gate drive
// - Channel-only stop coasts, no deceleration
// - Unmatched drop past window raises discrepancy
// - Matched drop within window reports open
// - Window one second or ten milliseconds
// - Single fault locks out, torque stays off
// - Enable allowed once external fault clears
// - Torque-off within 100 ms of demand
`include "stop_monitor_params.svh"
module safe_stop_monitor #(
	parameter int WINDOW_NEW = `WINDOW_NEW_CYCLES,
	parameter int WINDOW_OLD = `WINDOW_OLD_CYCLES,
	parameter int SYNC_STAGES = `SYNC_STAGES
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic clk_en,
	// Safety channel pins
	input wire logic safety_channel_a,
	input wire logic safety_channel_b,
	// Configuration
	input wire logic new_firmware_window,
	input wire logic open_condition_fault_enable,
	// Drive commands, same clock
	input wire logic start_cmd,
	input wire logic stop_cmd,
	input wire logic fault_reset,
	// Status and gate control
	output logic gate_enable,
	output logic decel_request,
	output logic drive_ready,
	output logic drive_running,
	output logic channel_discrepancy_fault,
	output logic safety_open_condition,
	output stop_monitor_pkg::monitor_state_type monitor_state
);
	import stop_monitor_pkg::*;

	logic chan_a;
	logic chan_b;
	logic both_on;
	logic both_off;
	logic [31:0] window_count;
	logic [31:0] window_limit;
	logic window_expired;

	channel_sync #(.STAGES(SYNC_STAGES)) sync_a (
		.mclk(mclk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.pin(safety_channel_a),
		.synced(chan_a)
	);

	channel_sync #(.STAGES(SYNC_STAGES)) sync_b (
		.mclk(mclk),
		.rst_b(rst_b),
		.clk_en(clk_en),
		.pin(safety_channel_b),
		.synced(chan_b)
	);

	assign both_on = chan_a && chan_b;
	assign both_off = !chan_a && !chan_b;
	assign window_limit = new_firmware_window ? 32'(WINDOW_NEW) : 32'(WINDOW_OLD);
	assign window_expired = window_count >= window_limit;

	// Discrepancy timer runs only while channels disagree
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			window_count <= 32'h00000000;
		end else if (clk_en) begin
			if (both_on || both_off) begin
				window_count <= 32'h00000000;
			end else if (!window_expired) begin
				window_count <= window_count + 32'h00000001;
			end
		end
	end

	// Main state
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			monitor_state <= st_safe;
		end else if (clk_en) begin
			unique case (monitor_state)
				st_safe: begin
					if (both_on) begin
						monitor_state <= st_ready;
					end else if (both_off) begin
						monitor_state <= st_open;
					end else begin
						monitor_state <= st_mismatch;
					end
				end
				st_ready, st_run: begin
					if (both_off) begin
						monitor_state <= st_open;
					end else if (!both_on) begin
						monitor_state <= st_mismatch;
					end else if (monitor_state == st_ready && start_cmd && !stop_cmd) begin
						monitor_state <= st_run;
					end else if (monitor_state == st_run && stop_cmd) begin
						monitor_state <= st_ready;
					end
				end
				st_mismatch: begin
					if (both_off) begin
						monitor_state <= st_open;
					end else if (both_on) begin
						monitor_state <= st_ready;
					end else if (window_expired) begin
						monitor_state <= st_fault;
					end
				end
				st_open: begin
					if (both_on) begin
						monitor_state <= st_ready;
					end else if (!both_off) begin
						monitor_state <= st_mismatch;
					end
				end
				st_fault: begin
					if (both_on && fault_reset) begin
						monitor_state <= st_ready;
					end
				end
				default: begin
					monitor_state <= st_safe;
				end
			endcase
		end
	end

	// Gate drive needs both synchronised channels and the run state
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			gate_enable <= 1'b0;
		end else if (clk_en) begin
			gate_enable <= both_on && (monitor_state == st_run);
		end
	end

	// Status flags
	always_ff @(posedge mclk) begin
		if (!rst_b) begin
			drive_ready <= 1'b0;
			drive_running <= 1'b0;
			channel_discrepancy_fault <= 1'b0;
			safety_open_condition <= 1'b0;
			decel_request <= 1'b0;
		end else if (clk_en) begin
			drive_ready <= both_on && (monitor_state == st_ready);
			drive_running <= both_on && (monitor_state == st_run);
			channel_discrepancy_fault <= monitor_state == st_fault;
			safety_open_condition <= (monitor_state == st_open) && open_condition_fault_enable;
			decel_request <= both_on && stop_cmd && (monitor_state == st_run);
		end
	end

	// Gate off one cycle after a synchronised drop
	a_gate_drop: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && !both_on |=> !gate_enable)
		else $error("gate still enabled after channel drop");

	a_run_needs_both: assert property (@(posedge mclk) disable iff (!rst_b)
		drive_ready || drive_running |-> $past(both_on))
		else $error("ready or run without both channels");

	a_no_decel_on_drop: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && !both_on |=> !decel_request)
		else $error("deceleration requested on channel stop");

	// Steps of a discrepancy trip
	sequence s_window_out;
		clk_en && monitor_state == st_mismatch && window_expired && !both_on && !both_off;
	endsequence

	sequence s_fault_raise;
		!channel_discrepancy_fault ##1 channel_discrepancy_fault;
	endsequence

	// Pin drop seen over three enabled edges
	sequence s_pin_drop;
		clk_en && (!safety_channel_a || !safety_channel_b) ##1 clk_en ##1 clk_en;
	endsequence

	a_mismatch_fault: assert property (@(posedge mclk) disable iff (!rst_b)
		s_window_out |=> s_fault_raise)
		else $error("discrepancy fault not raised after window");

	a_reaction_time: assert property (@(posedge mclk) disable iff (!rst_b)
		s_pin_drop |=> !gate_enable)
		else $error("gate not off within reaction time");

	a_open_not_fault: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && monitor_state == st_mismatch && both_off |=> monitor_state == st_open)
		else $error("follow within window not reported as open");

	a_open_enable: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && monitor_state == st_open && !open_condition_fault_enable |=> !safety_open_condition)
		else $error("open reported while disabled");

	a_fault_lock: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && monitor_state == st_fault && !(both_on && fault_reset) |=> monitor_state == st_fault)
		else $error("discrepancy fault released without reset");

	a_fault_torque_off: assert property (@(posedge mclk) disable iff (!rst_b)
		monitor_state == st_fault |=> !gate_enable)
		else $error("gate enabled during lockout");

	a_window_bound: assert property (@(posedge mclk) disable iff (!rst_b)
		window_count <= window_limit)
		else $error("discrepancy timer past window");

	a_rearm: assert property (@(posedge mclk) disable iff (!rst_b)
		clk_en && monitor_state == st_open && both_on |=> monitor_state == st_ready)
		else $error("no re-enable once channels return");
endmodule // safe_stop_monitor

//--- testbench/safety_relay_model.sv
module safety_relay_model (
	// Clock
	input wire logic mclk,
	// Contact commands
	input wire logic close_a,
	input wire logic close_b,
	// Channels
	output logic ch_a,
	output logic ch_b
);
	timeunit 1ns;
	timeprecision 1ps;
	// Contacts follow commands a cycle later
	always_ff @(posedge mclk) begin
		ch_a <= close_a;
		ch_b <= close_b;
	end
endmodule // safety_relay_model

//--- testbench/tb_safe_stop_monitor.sv
module tb_safe_stop_monitor;
	timeunit 1ns;
	timeprecision 1ps;
	import stop_monitor_pkg::*;
	logic mclk = 0, rst_b = 0, close_a = 1, close_b = 1, nw = 1, en = 1;
	logic start_cmd = 0, stop_cmd = 0, fault_reset = 0, clk_en = 1;
	logic ch_a, ch_b, gate, decel, ready, running, disc, open_c;
	monitor_state_type state;
	int n_fail = 0, num_checks = 0, cycles = 0;
	always #2.5 mclk = ~mclk;
	safety_relay_model relay_u (.mclk(mclk), .close_a(close_a), .close_b(close_b), .ch_a(ch_a), .ch_b(ch_b));
	safe_stop_monitor #(.WINDOW_NEW(20), .WINDOW_OLD(5)) dut_u (.mclk(mclk), .rst_b(rst_b), .clk_en(clk_en),
		.safety_channel_a(ch_a), .safety_channel_b(ch_b), .new_firmware_window(nw),
		.open_condition_fault_enable(en), .start_cmd(start_cmd), .stop_cmd(stop_cmd),
		.fault_reset(fault_reset), .gate_enable(gate), .decel_request(decel), .drive_ready(ready),
		.drive_running(running), .channel_discrepancy_fault(disc), .safety_open_condition(open_c),
		.monitor_state(state));
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask
	task automatic chk(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic chk_state(input monitor_state_type got, input monitor_state_type exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("BAD %0t %s", $time, what);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d fails %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	task automatic run_up;
		close_a = 1;
		close_b = 1;
		cyc(8);
		chk(ready, 1, "ready");
		chk(gate, 0, "gate before start");
		start_cmd = 1;
		cyc(1);
		start_cmd = 0;
		cyc(4);
		chk(gate, 1, "gate in run");
		chk(running, 1, "running");
		chk_state(state, st_run, "state run");
	endtask
	task automatic recover(input logic exp_fault);
		close_a = 1;
		close_b = 1;
		cyc(8);
		chk(disc, exp_fault, "latched");
		fault_reset = 1;
		cyc(1);
		fault_reset = 0;
		cyc(4);
		chk(disc, 0, "cleared");
		chk(ready, 1, "ready again");
		chk_state(state, st_ready, "state ready again");
	endtask
	task automatic t_drop(input logic w, input int lag, input logic e, input logic exp_fault);
		nw = w;
		en = e;
		run_up();
		close_a = 0;
		cyc(5);
		chk(gate, 0, "gate off");
		chk(decel, 0, "coast");
		chk_state(state, st_mismatch, "mismatch");
		cyc(lag - 5);
		close_b = 0;
		cyc(40);
		chk(disc, exp_fault, "discrepancy");
		chk(open_c, !exp_fault && e, "open");
		chk(gate, 0, "safe held");
		chk_state(state, exp_fault ? st_fault : st_open, "state after drop");
		recover(exp_fault);
	endtask
	task automatic t_single(input logic drop_b);
		nw = 1;
		run_up();
		close_a = drop_b;
		close_b = !drop_b;
		cyc(40);
		chk(disc, 1, "single fault");
		chk(gate, 0, "gate locked");
		chk(ready, 0, "not ready");
		chk_state(state, st_fault, "state locked");
		recover(1);
	endtask
	task automatic t_stop;
		run_up();
		stop_cmd = 1;
		cyc(1);
		chk(decel, 1, "decel");
		cyc(2);
		chk(decel, 0, "decel ends");
		chk(running, 0, "stopped");
		close_a = 0;
		close_b = 0;
		cyc(30);
		chk(open_c, 1, "open after stop");
		chk(disc, 0, "no discrepancy");
		stop_cmd = 0;
		recover(0);
		run_up();
	endtask
	task automatic t_freeze;
		clk_en = 0;
		close_a = 0;
		cyc(10);
		chk(gate, 1, "gate frozen");
		chk_state(state, st_run, "state frozen");
		clk_en = 1;
		cyc(5);
		chk(gate, 0, "gate off after thaw");
		chk_state(state, st_mismatch, "mismatch after thaw");
		recover(0);
	endtask
	task automatic t_reset;
		run_up();
		rst_b = 0;
		cyc(1);
		chk(gate, 0, "gate in reset");
		chk_state(state, st_safe, "state in reset");
		cyc(3);
		rst_b = 1;
		cyc(8);
		chk(ready, 1, "ready after reset");
		chk(open_c, 0, "open cleared");
		chk_state(state, st_ready, "state after reset");
	endtask
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 5000) begin
			n_fail++;
			finish_test();
		end
	end
	initial begin
		cyc(4);
		rst_b = 1;
		t_drop(1, 12, 1, 0);
		t_drop(1, 12, 0, 0);
		t_drop(0, 12, 1, 1);
		t_single(0);
		t_single(1);
		t_stop();
		t_freeze();
		t_reset();
		finish_test();
	end
endmodule // tb_safe_stop_monitor
